// File: verilog/bbp_pkg.sv
// Constants, opcodes and carrier types of the one-bit instruction unit.
package bbp_pkg;

    // =====================================================================
    // Opcodes of the one-bit subset
    localparam logic [7:0] OP_SET_C    = 8'hD3;
    localparam logic [7:0] OP_SET_B    = 8'hD2;
    localparam logic [7:0] OP_CLR_C    = 8'hC3;
    localparam logic [7:0] OP_CLR_B    = 8'hC2;
    localparam logic [7:0] OP_INV_C    = 8'hB3;
    localparam logic [7:0] OP_INV_B    = 8'hB2;
    localparam logic [7:0] OP_MOV_CB   = 8'hA2;
    localparam logic [7:0] OP_MOV_BC   = 8'h92;
    localparam logic [7:0] OP_AND_B    = 8'h82;
    localparam logic [7:0] OP_AND_NB   = 8'hB0;
    localparam logic [7:0] OP_OR_B     = 8'h72;
    localparam logic [7:0] OP_OR_NB    = 8'hA0;
    localparam logic [7:0] OP_BR_C     = 8'h40;
    localparam logic [7:0] OP_BR_NC    = 8'h50;
    localparam logic [7:0] OP_BR_B1    = 8'h20;
    localparam logic [7:0] OP_BR_B0    = 8'h30;
    localparam logic [7:0] OP_BR_BCLR  = 8'h10;

    // =====================================================================
    // Bit space layout
    localparam logic [7:0] RAM_BIT_BASE = 8'h20;
    localparam logic [7:0] STATUS_ADDR  = 8'hD0;
    localparam int         CARRY_POS    = 7;
    localparam int         SFR_SEL_BIT  = 7;

    // =====================================================================
    // Timing and reset values
    localparam int          MC_CLKS_DEF = 12;
    localparam int          CNT_W       = 5;
    localparam logic [15:0] PC_RESET    = 16'h0000;

    typedef enum logic [3:0] {
        K_NONE, K_SET, K_CLR, K_INV, K_MOVCB, K_MOVBC, K_AND, K_ANDN,
        K_OR, K_ORN, K_BRC, K_BRNC, K_BRB1, K_BRB0, K_BRBC
    } bbp_kind_type;

    typedef struct packed {
        bbp_kind_type kind;
        logic         uses_bit;   // Direct bit address follows opcode
        logic [1:0]   len;        // Bytes in encoding
        logic [1:0]   cycles;     // Instruction cycles
    } bbp_dec_type;

    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
    } bbp_pm_req_type;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bbp_dm_req_type;

endpackage

// File: verilog/bbp_core.sv
// One-bit instruction fetch, decode and execute unit.
`timescale 1ns/100ps
module bbp_core
    import bbp_pkg::*;
#(
    parameter int MC_CLKS = MC_CLKS_DEF
) (
    input  wire logic           REF_CLK_I,  // 25 MHz clock
    input  wire logic           RST_I,      // Synchronous reset, high
    input  wire logic           CE_I,       // Clock enable
    output bbp_pm_req_type      PM_REQ_O,   // Program memory read
    input  wire logic [7:0]     PM_DATA_I,  // Program byte
    output bbp_dm_req_type      DM_REQ_O,   // Data space access
    input  wire logic [7:0]     DM_RDATA_I, // Data space byte
    output logic                CARRY_O,    // Carry flag
    output logic [15:0]         PC_O,       // Program counter
    output logic                RETIRE_O,   // Instruction done pulse
    output logic                FOREIGN_O   // Opcode outside subset
);

    // =====================================================================
    // Decode
    function automatic bbp_dec_type decode(input logic [7:0] op);
        bbp_dec_type d;
        d = '{kind: K_NONE, uses_bit: 1'b0, len: 2'd1, cycles: 2'd1};
        unique case (op)
            OP_SET_C:   d.kind = K_SET;
            OP_CLR_C:   d.kind = K_CLR;
            OP_INV_C:   d.kind = K_INV;
            OP_SET_B:   d = '{K_SET, 1'b1, 2'd2, 2'd1};
            OP_CLR_B:   d = '{K_CLR, 1'b1, 2'd2, 2'd1};
            OP_INV_B:   d = '{K_INV, 1'b1, 2'd2, 2'd1};
            OP_MOV_CB:  d = '{K_MOVCB, 1'b1, 2'd2, 2'd1};
            OP_MOV_BC:  d = '{K_MOVBC, 1'b1, 2'd2, 2'd2};
            OP_AND_B:   d = '{K_AND, 1'b1, 2'd2, 2'd2};
            OP_AND_NB:  d = '{K_ANDN, 1'b1, 2'd2, 2'd2};
            OP_OR_B:    d = '{K_OR, 1'b1, 2'd2, 2'd2};
            OP_OR_NB:   d = '{K_ORN, 1'b1, 2'd2, 2'd2};
            OP_BR_C:    d = '{K_BRC, 1'b0, 2'd2, 2'd2};
            OP_BR_NC:   d = '{K_BRNC, 1'b0, 2'd2, 2'd2};
            OP_BR_B1:   d = '{K_BRB1, 1'b1, 2'd3, 2'd2};
            OP_BR_B0:   d = '{K_BRB0, 1'b1, 2'd3, 2'd2};
            OP_BR_BCLR: d = '{K_BRBC, 1'b1, 2'd3, 2'd2};
            default:    d = d;
        endcase
        return d;
    endfunction

    // Byte holding a given bit of the bit space
    function automatic logic [7:0] bit_byte(input logic [7:0] ba);
        if (ba[SFR_SEL_BIT]) begin
            return {ba[7:3], 3'b000};
        end
        return RAM_BIT_BASE + {4'h0, ba[6:3]};
    endfunction

    // =====================================================================
    // State
    typedef enum logic [4:0] {
        S_FETCH = 5'b00001,
        S_READ  = 5'b00010,
        S_EXEC  = 5'b00100,
        S_WAIT  = 5'b01000,
        S_IDLE  = 5'b10000
    } bbp_state_type;

    bbp_state_type  state;
    bbp_state_type  next_state;
    logic [1:0]     phase;
    logic [1:0]     byte_idx;
    logic [7:0]     opcode;
    logic [7:0]     bit_addr;
    logic [7:0]     disp;
    logic [7:0]     data_byte;
    logic [15:0]    pc;
    logic [15:0]    fetch_pc;
    logic           carry;
    logic           taken;
    logic [CNT_W-1:0] clk_cnt;
    bbp_pm_req_type pm_req;
    bbp_dm_req_type dm_req;

    // =====================================================================
    // Combinational decode and execute terms
    wire bbp_dec_type dec      = decode(opcode);
    wire logic        is_alias = (bit_byte(bit_addr) == STATUS_ADDR) &&
                                 (bit_addr[2:0] == 3'(CARRY_POS));
    wire logic [7:0]  rd_byte  = DM_RDATA_I;
    wire logic        bit_val  = is_alias ? carry : data_byte[bit_addr[2:0]];
    wire logic [1:0]  need_len = (byte_idx == 2'd0) ? 2'd1 : dec.len;
    wire logic        ph_last  = (phase == 2'd2);
    wire logic [15:0] next_pc  = pc + {14'h0, dec.len};
    wire logic [15:0] br_pc    = next_pc + {{8{disp[7]}}, disp};
    wire logic [CNT_W-1:0] end_cnt =
        CNT_W'(int'(dec.cycles) * MC_CLKS - 1);

    logic       next_carry;
    logic       next_bit;
    logic       do_write;
    logic       next_taken;

    // Result of the operation on carry and the addressed bit
    always_comb begin
        next_carry = carry;
        next_bit   = bit_val;
        do_write   = 1'b0;
        next_taken = 1'b0;
        unique case (dec.kind)
            K_SET, K_CLR, K_INV: begin
                if (dec.uses_bit) begin
                    next_bit = (dec.kind == K_SET) ? 1'b1 :
                               (dec.kind == K_CLR) ? 1'b0 : ~bit_val;
                    do_write = 1'b1;
                end else begin
                    next_carry = (dec.kind == K_SET) ? 1'b1 :
                                 (dec.kind == K_CLR) ? 1'b0 : ~carry;
                end
            end
            K_MOVCB: next_carry = bit_val;
            K_MOVBC: begin
                next_bit = carry;
                do_write = 1'b1;
            end
            K_AND:  next_carry = carry & bit_val;
            K_ANDN: next_carry = carry & ~bit_val;
            K_OR:   next_carry = carry | bit_val;
            K_ORN:  next_carry = carry | ~bit_val;
            K_BRC:  next_taken = carry;
            K_BRNC: next_taken = ~carry;
            K_BRB1: next_taken = bit_val;
            K_BRB0: next_taken = ~bit_val;
            K_BRBC: begin
                next_taken = bit_val;
                next_bit   = 1'b0;
                do_write   = bit_val;
            end
            K_NONE: next_taken = 1'b0;
        endcase
        if (do_write && is_alias) begin
            next_carry = next_bit;
        end
    end

    // Only the addressed bit changes in the written byte
    wire logic [7:0] wr_mask = 8'h01 << bit_addr[2:0];
    wire logic [7:0] wr_byte = (data_byte & ~wr_mask) |
                               (next_bit ? wr_mask : 8'h00);

    // =====================================================================
    // Sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            S_IDLE:  next_state = S_FETCH;
            S_FETCH: begin
                if (ph_last && (byte_idx + 2'd1 >= need_len)) begin
                    next_state = (byte_idx == 2'd0 && dec.len == 2'd1)
                                 ? S_FETCH : S_FETCH;
                end
                if (ph_last && byte_idx != 2'd0 &&
                    byte_idx + 2'd1 >= dec.len) begin
                    next_state = dec.uses_bit ? S_READ : S_EXEC;
                end
            end
            S_READ:  next_state = ph_last ? S_EXEC : S_READ;
            S_EXEC:  next_state = S_WAIT;
            S_WAIT:  next_state = (clk_cnt >= end_cnt) ? S_FETCH : S_WAIT;
        endcase
    end

    // Opcode byte just captured: decode of the live byte decides length
    wire bbp_dec_type op_dec  = decode(PM_DATA_I);
    wire logic        op_done = (state == S_FETCH) && ph_last &&
                                (byte_idx == 2'd0);
    wire logic        op_one  = op_done && (op_dec.len == 2'd1);

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state     <= S_IDLE;
            phase     <= 2'd0;
            byte_idx  <= 2'd0;
            opcode    <= 8'h00;
            bit_addr  <= 8'h00;
            disp      <= 8'h00;
            data_byte <= 8'h00;
            pc        <= PC_RESET;
            fetch_pc  <= PC_RESET;
            carry     <= 1'b0;
            taken     <= 1'b0;
            clk_cnt   <= '0;
            pm_req    <= '0;
            dm_req    <= '0;
            RETIRE_O  <= 1'b0;
            FOREIGN_O <= 1'b0;
        end else if (CE_I) begin
            pm_req.rd <= 1'b0;
            dm_req.rd <= 1'b0;
            dm_req.wr <= 1'b0;
            RETIRE_O  <= 1'b0;
            FOREIGN_O <= 1'b0;
            clk_cnt   <= clk_cnt + CNT_W'(1);
            state     <= op_one ? S_EXEC : next_state;
            unique case (state)
                S_IDLE: begin
                    fetch_pc <= pc;
                    clk_cnt  <= '0;
                    phase    <= 2'd0;
                    byte_idx <= 2'd0;
                end
                S_FETCH: begin
                    // Issue, memory latches, capture
                    phase <= ph_last ? 2'd0 : phase + 2'd1;
                    if (phase == 2'd0) begin
                        pm_req <= '{rd: 1'b1, addr: fetch_pc};
                        if (byte_idx == 2'd0) begin
                            clk_cnt <= CNT_W'(1);
                        end
                    end
                    if (ph_last) begin
                        fetch_pc <= fetch_pc + 16'h0001;
                        byte_idx <= byte_idx + 2'd1;
                        unique case (byte_idx)
                            2'd0:    opcode <= PM_DATA_I;
                            2'd1: begin
                                if (dec.uses_bit) begin
                                    bit_addr <= PM_DATA_I;
                                end else begin
                                    disp <= PM_DATA_I;
                                end
                            end
                            default: disp <= PM_DATA_I;
                        endcase
                    end
                end
                S_READ: begin
                    phase <= ph_last ? 2'd0 : phase + 2'd1;
                    if (phase == 2'd0 && !is_alias) begin
                        dm_req.rd   <= 1'b1;
                        dm_req.addr <= bit_byte(bit_addr);
                    end
                    if (ph_last) begin
                        data_byte <= is_alias ? 8'h00 : rd_byte;
                    end
                end
                S_EXEC: begin
                    carry <= next_carry;
                    taken <= next_taken;
                    FOREIGN_O <= (dec.kind == K_NONE);
                    if (do_write && !is_alias) begin
                        dm_req <= '{rd: 1'b0, wr: 1'b1,
                                    addr: bit_byte(bit_addr),
                                    wdata: wr_byte};
                    end
                end
                S_WAIT: begin
                    if (clk_cnt >= end_cnt) begin
                        // Hold until the documented cycle count ends
                        pc       <= taken ? br_pc : next_pc;
                        fetch_pc <= taken ? br_pc : next_pc;
                        RETIRE_O <= 1'b1;
                        taken    <= 1'b0;
                        byte_idx <= 2'd0;
                        phase    <= 2'd0;
                        clk_cnt  <= '0;
                    end
                end
            endcase
            if (op_one) begin
                byte_idx <= 2'd0;
            end
        end
    end

    assign PM_REQ_O = pm_req;
    assign DM_REQ_O = dm_req;
    assign CARRY_O  = carry;
    assign PC_O     = pc;

endmodule

// File: verif/bbp_mem.sv
// Program memory and bit-addressable data space seen by the unit.
`timescale 1ns/100ps
module bbp_mem
    import bbp_pkg::*;
(
    input  wire logic           clk_i,      // Unit clock
    input  wire bbp_pm_req_type pm_req_i,   // Program fetch
    output logic [7:0]          pm_data_o,  // Program byte
    input  wire bbp_dm_req_type dm_req_i,   // Data access
    output logic [7:0]          dm_rdata_o  // Data byte
);
    logic [7:0] pmem [256];
    logic [7:0] dmem [256];
    logic       pv = 1'b0;
    logic       dv = 1'b0;

    initial begin
        pm_data_o  = 8'h00;
        dm_rdata_o = 8'h00;
        for (int i = 0; i < 256; i++) begin
            pmem[i] = 8'h00;
            dmem[i] = 8'h00;
        end
    end

    // =====================================================
    // Latch on the edge that sees the strobe, byte stands one cycle
    // Afterwards the byte is inverted so a late sample is caught
    always @(posedge clk_i) begin
        pv <= pm_req_i.rd;
        dv <= dm_req_i.rd;
        if (pm_req_i.rd) pm_data_o <= pmem[pm_req_i.addr[7:0]];
        else if (pv) pm_data_o <= ~pm_data_o;
        if (dm_req_i.rd) dm_rdata_o <= dmem[dm_req_i.addr];
        else if (dv) dm_rdata_o <= ~dm_rdata_o;
        if (dm_req_i.wr) dmem[dm_req_i.addr] <= dm_req_i.wdata;
    end
endmodule

// File: verif/bbp_core_asserts.sv
// Concurrent checks on the ports of the one-bit instruction unit.
`timescale 1ns/100ps
module bbp_core_asserts
    import bbp_pkg::*;
#(
    parameter int MC_CLKS = MC_CLKS_DEF
) (
    input wire logic           REF_CLK_I,  // Unit clock
    input wire logic           RST_I,      // Reset, high
    input wire logic           CE_I,       // Clock enable
    input wire bbp_pm_req_type PM_REQ_O,   // Program fetch
    input wire logic [7:0]     PM_DATA_I,  // Program byte
    input wire bbp_dm_req_type DM_REQ_O,   // Data access
    input wire logic [7:0]     DM_RDATA_I, // Data byte
    input wire logic           CARRY_O,    // Carry flag
    input wire logic [15:0]    PC_O,       // Program counter
    input wire logic           RETIRE_O,   // Retire pulse
    input wire logic           FOREIGN_O   // Unknown opcode
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    logic [7:0] gap;
    logic       seen;
    logic [1:0] rq;
    logic [7:0] rbyte;
    wire        dm_any = DM_REQ_O.rd | DM_REQ_O.wr;

    // =====================================================
    // Helpers; strobe checks assume CE_I stays high
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            gap  <= 8'h00;
            seen <= 1'b0;
            rq   <= 2'h0;
        end else if (CE_I) begin
            gap  <= RETIRE_O ? 8'h01 : gap + 8'h01;
            seen <= seen | RETIRE_O;
            rq   <= {rq[0], DM_REQ_O.rd};
            if (rq[0]) rbyte <= DM_RDATA_I;
        end
    end

    sequence pm_quiet;
        !PM_REQ_O.rd [*2];
    endsequence
    sequence dm_quiet;
        !DM_REQ_O.rd && !DM_REQ_O.wr;
    endsequence

    retire_period_a: assert property (RETIRE_O && seen |->
        gap == 8'(MC_CLKS) || gap == 8'(2 * MC_CLKS))
        else $error("retire spacing not a whole instruction cycle");
    pc_on_retire_a: assert property ($changed(PC_O) |-> RETIRE_O)
        else $error("program counter moved without retire");
    fetch_spacing_a: assert property (PM_REQ_O.rd |=> pm_quiet)
        else $error("program fetches closer than three cycles");
    dm_pulse_a: assert property (dm_any |=> dm_quiet)
        else $error("data strobe longer than one cycle");
    data_excl_a: assert property (!(DM_REQ_O.rd && DM_REQ_O.wr))
        else $error("data read and write together");
    ram_window_a: assert property (dm_any && !DM_REQ_O.addr[7] |->
        DM_REQ_O.addr[7:4] == 4'h2)
        else $error("low bit address outside the flag bytes");
    sfr_align_a: assert property (dm_any && DM_REQ_O.addr[7] |->
        DM_REQ_O.addr[2:0] == 3'h0)
        else $error("register byte address not aligned");
    carry_alias_a: assert property (DM_REQ_O.wr &&
        DM_REQ_O.addr == STATUS_ADDR |->
        DM_REQ_O.wdata[CARRY_POS] == rbyte[CARRY_POS])
        else $error("carry position of status byte written");
    single_bit_a: assert property (DM_REQ_O.wr |->
        $countones(DM_REQ_O.wdata ^ rbyte) <= 1)
        else $error("write changes more than one bit");
    reset_values_a: assert property (disable iff (1'b0) RST_I |=>
        !CARRY_O && PC_O == PC_RESET && !RETIRE_O && !PM_REQ_O.rd)
        else $error("outputs not at reset values");
endmodule

bind bbp_core bbp_core_asserts #(.MC_CLKS(MC_CLKS)) bbp_core_asserts_i (
    .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .CE_I(CE_I),
    .PM_REQ_O(PM_REQ_O), .PM_DATA_I(PM_DATA_I), .DM_REQ_O(DM_REQ_O),
    .DM_RDATA_I(DM_RDATA_I), .CARRY_O(CARRY_O), .PC_O(PC_O),
    .RETIRE_O(RETIRE_O), .FOREIGN_O(FOREIGN_O));

// File: verif/boolean_bit_processor_tb.sv
// Self-checking bench for the one-bit instruction unit.
`timescale 1ns/100ps
module boolean_bit_processor_tb
    import bbp_pkg::*;
;
    typedef struct packed {
        logic [7:0] b0, b1, b2, din, eb;
        logic [1:0] len, cyc;
        logic       cin, ec, tk;
    } bbp_row_type;

    localparam int MC   = 12;
    localparam int NROW = 20;
    logic           ref_clk = 1'b0;
    logic           rst     = 1'b1;
    bbp_pm_req_type pm_req;
    logic [7:0]     pm_data;
    bbp_dm_req_type dm_req;
    logic [7:0]     dm_rdata;
    logic           carry;
    logic [15:0]    pc;
    logic           retire;
    logic           foreign;
    logic [15:0]    exp_pc;
    logic           fgn;
    bbp_row_type    r;
    int             num_errors  = 0;
    int             check_count = 0;
    int             cycles      = 0;
    // Opcode, bit or displacement bytes, byte before and after, sizes
    bbp_row_type rows [NROW] = '{
        '{8'hD3,8'h00,8'h00,8'h00,8'h00,2'h1,2'h1,1'h0,1'h1,1'h0},
        '{8'hC3,8'h00,8'h00,8'h00,8'h00,2'h1,2'h1,1'h1,1'h0,1'h0},
        '{8'hB3,8'h00,8'h00,8'h00,8'h00,2'h1,2'h1,1'h1,1'h0,1'h0},
        '{8'hD2,8'h05,8'h00,8'h00,8'h20,2'h2,2'h1,1'h0,1'h0,1'h0},
        '{8'hC2,8'h7F,8'h00,8'hFF,8'h7F,2'h2,2'h1,1'h1,1'h1,1'h0},
        '{8'hB2,8'h88,8'h00,8'h5A,8'h5B,2'h2,2'h1,1'h0,1'h0,1'h0},
        '{8'hA2,8'h0A,8'h00,8'h04,8'h04,2'h2,2'h1,1'h0,1'h1,1'h0},
        '{8'h92,8'h13,8'h00,8'h00,8'h08,2'h2,2'h2,1'h1,1'h1,1'h0},
        '{8'h82,8'hF9,8'h00,8'h00,8'h00,2'h2,2'h2,1'h1,1'h0,1'h0},
        '{8'hB0,8'h00,8'h00,8'h00,8'h00,2'h2,2'h2,1'h1,1'h1,1'h0},
        '{8'h72,8'hE7,8'h00,8'h80,8'h80,2'h2,2'h2,1'h0,1'h1,1'h0},
        '{8'hA0,8'h31,8'h00,8'hFF,8'hFF,2'h2,2'h2,1'h0,1'h0,1'h0},
        '{8'h40,8'h10,8'h00,8'h00,8'h00,2'h2,2'h2,1'h1,1'h1,1'h1},
        '{8'h50,8'h05,8'h00,8'h00,8'h00,2'h2,2'h2,1'h1,1'h1,1'h0},
        '{8'h20,8'h40,8'h80,8'h01,8'h01,2'h3,2'h2,1'h0,1'h0,1'h1},
        '{8'h30,8'h40,8'h7F,8'h01,8'h01,2'h3,2'h2,1'h0,1'h0,1'h0},
        '{8'h10,8'h99,8'h7F,8'h02,8'h00,2'h3,2'h2,1'h1,1'h1,1'h1},
        '{8'hD2,8'hD7,8'h00,8'h00,8'h00,2'h2,2'h1,1'h0,1'h1,1'h0},
        '{8'h00,8'h00,8'h00,8'h00,8'h00,2'h1,2'h1,1'h1,1'h1,1'h0},
        '{8'h50,8'hFE,8'h00,8'h00,8'h00,2'h2,2'h2,1'h0,1'h0,1'h1}};

    always #20 ref_clk = ~ref_clk;

    bbp_core #(.MC_CLKS(MC)) bbp_core_i (.REF_CLK_I(ref_clk), .RST_I(rst),
        .CE_I(1'b1), .PM_REQ_O(pm_req), .PM_DATA_I(pm_data),
        .DM_REQ_O(dm_req), .DM_RDATA_I(dm_rdata), .CARRY_O(carry),
        .PC_O(pc), .RETIRE_O(retire), .FOREIGN_O(foreign));
    bbp_mem bbp_mem_i (.clk_i(ref_clk), .pm_req_i(pm_req),
        .pm_data_o(pm_data), .dm_req_i(dm_req), .dm_rdata_o(dm_rdata));

    // =====================================================
    // Checking and instruction tasks
    task automatic chk(input string nm, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask

    function automatic logic [7:0] byte_of(input logic [7:0] a);
        return a[7] ? {a[7:3], 3'h0} : 8'h20 + {4'h0, a[6:3]};
    endfunction

    // Bytes go in just after the previous retire, ahead of the fetch
    task automatic exec(input logic [7:0] b0, b1, b2,
                        input logic [1:0] len, cyc, input logic tk);
        logic [7:0] d;
        int         n;
        d   = (len == 2'h3) ? b2 : b1;
        n   = 0;
        fgn = 1'b0;
        bbp_mem_i.pmem[exp_pc[7:0]]        = b0;
        bbp_mem_i.pmem[exp_pc[7:0] + 8'h1] = b1;
        bbp_mem_i.pmem[exp_pc[7:0] + 8'h2] = b2;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
            fgn = fgn | foreign;
        end while (retire !== 1'b1 && n < 100);
        if (cyc != 2'h0) chk("cycles", 16'(MC * cyc), n[15:0]);
        exp_pc = exp_pc + 16'(len) + (tk ? {{8{d[7]}}, d} : 16'h0);
        chk("pc", exp_pc, pc);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            results();
        end
    end

    // =====================================================
    // Table rows, then a reset in mid-instruction
    initial begin
        repeat (10) @(posedge ref_clk);
        #1;
        chk("reset carry", 16'h0000, carry);
        chk("reset pc", PC_RESET, pc);
        rst    = 1'b0;
        exp_pc = PC_RESET;
        for (int i = 0; i < NROW; i++) begin
            r = rows[i];
            bbp_mem_i.dmem[byte_of(r.b1)] = r.din;
            exec(r.cin ? OP_SET_C : OP_CLR_C, 8'h00, 8'h00, 2'h1,
                 (i == 0) ? 2'h0 : 2'h1, 1'b0);
            exec(r.b0, r.b1, r.b2, r.len, r.cyc, r.tk);
            chk("carry", r.ec, carry);
            chk("byte", r.eb, bbp_mem_i.dmem[byte_of(r.b1)]);
            chk("foreign", r.b0 == 8'h00, fgn);
        end
        repeat (5) @(posedge ref_clk);
        #1;
        rst = 1'b1;
        repeat (10) begin
            @(posedge ref_clk);
            #1;
            chk("reset fetch", 16'h0000, pm_req.rd);
        end
        chk("reset carry", 16'h0000, carry);
        chk("reset pc", PC_RESET, pc);
        rst    = 1'b0;
        exp_pc = PC_RESET;
        exec(OP_SET_C, 8'h00, 8'h00, 2'h1, 2'h0, 1'b0);
        chk("carry", 16'h0001, carry);
        results();
    end
endmodule
